/* pmc_power_mode_controller.sv */
// Power mode controller: Active, Power Save, Idle and Halt sequencing.
// Assumes clock stability flags and wake-up/wait strobes arrive asynchronously.
`timescale 1ns/1ns

// Function
// R1: Power-save write with wait bit clear starts Power Save entry immediately.
// R2: Power-save write with wait bit set defers entry to WAIT.
// R3: Immediate case: power-save bit reads set only after entry completes.
// R4: Deferred case: power-save bit reads set at once on write.
// R5: Software clears power-save bit; wake-up clears it too.
// R6: Idle bit with wait bit set enters Idle at WAIT, only from Active.
// R7: Idle bit set/clear by software, cleared by wake-up.
// R8: Halt bit with wait bit set enters Halt at WAIT.
// R9: Halt stops system clock first, then PLL and oscillator.
// R10: Wake in Halt restarts oscillator; halt bit clears once stable.
// R11: Wait bit 0 immediate transitions; 1 holds until WAIT.
// R12: With wait bit set, oscillator/PLL disable only after low-power entry.
// R13: Main-clock-disable stops oscillator in Power Save; Active ignores it.
// R14: Wake-up clears the main-clock-disable bit.
// R15: PLL off in Power Save when disabled; on when clear and not powered down.
// R16: Wake-up clears the PLL-disable bit.
// R17: Software sets both disable bits before Idle or Halt.
// R18: No entry to low-power modes while low-frequency flag is 0.
// R19: No switch to Active while main oscillator flag is 0.
// R20: PLL flag 1 when stable or disabled; unstable PLL blocks Active.
// R21: Status upper 5 bits zero; low three bits show live clock state.
// R22: Wake-up stays latched until interrupt acknowledge or reset.
// R23: Wake: clear osc disable, wait osc, clear PLL disable, wait PLL, Active.
// R24: Wake-up sources are NMI and the wake-up input unit.
// R25: Software clears power-save; bit changes only after Active reached.
// R26: One state machine; one low-power indication at most; Active after reset.
module pmc_power_mode_controller
(
	// Clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_sys_rst,
	// Register port
	input  wire logic [3:0] i_reg_addr,
	input  wire logic [7:0] i_reg_wdata,
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	output logic      [7:0] o_reg_rdata,
	// CPU events
	input  wire logic       i_cpu_wait,
	input  wire logic       i_int_ack,
	// Wake-up sources
	input  wire logic       i_nmi,
	input  wire logic       i_wakeup_input_unit,
	// Clock source status
	input  wire logic       i_low_freq_stable,
	input  wire logic       i_main_osc_stable,
	input  wire logic       i_pll_locked,
	input  wire logic       i_pll_power_down,
	// Clock controls and wake-up pending flag
	output logic            o_sys_clk_en,
	output logic            o_sys_clk_slow,
	output logic            o_main_osc_en,
	output logic            o_pll_en,
	output logic            o_wakeup_pending
);

	// Synchronised asynchronous inputs
	logic [6:0] sync1_q;
	logic [6:0] sync2_q;
	logic       s_wait;
	logic       s_ack;
	logic       s_wake;
	logic       s_lf_ok;
	logic       s_mo_ok;
	logic       s_pll_lock;
	logic       s_pll_pd;

	// State and registers
	pmc_pkg::pmc_state_type state_q;
	logic       psave_q;
	logic       idle_q;
	logic       halt_q;
	logic       wblp_q;
	logic       mdis_q;
	logic       pdis_q;
	logic       ps_pend_q;
	logic       wake_q;
	logic [1:0] gate_cnt_q;
	logic       pll_stable;
	logic       wr_ctl;
	logic       wake_done;
	logic       low_power;
	logic       go_ps_now;
	logic       go_wait;

	// Two-stage synchroniser for the CPU event, wake-up and clock status pins
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			sync1_q <= 7'h00;
			sync2_q <= 7'h00;
		end
		else
		begin
			sync1_q <= {i_cpu_wait, i_int_ack, i_nmi | i_wakeup_input_unit,
				i_low_freq_stable, i_main_osc_stable, i_pll_locked, i_pll_power_down};
			sync2_q <= sync1_q;
		end
	end

	// Synchronised views
	assign s_wait     = sync2_q[6];
	assign s_ack      = sync2_q[5];
	assign s_wake     = sync2_q[4]; // [R24]
	assign s_lf_ok    = sync2_q[3];
	assign s_mo_ok    = sync2_q[2];
	assign s_pll_lock = sync2_q[1];
	assign s_pll_pd   = sync2_q[0];

	// PLL flag reads stable whenever the PLL is not running
	assign pll_stable = s_pll_lock | ~o_pll_en; // [R20]

	assign wr_ctl    = i_reg_wr && (i_reg_addr == pmc_pkg::ADDR_CONTROL);
	assign low_power = (state_q != pmc_pkg::ST_ACTIVE);
	// Immediate power-save request
	assign go_ps_now = ps_pend_q && !wblp_q && s_lf_ok; // [R1] [R11] [R18]
	// WAIT-triggered entry
	assign go_wait   = s_wait && wblp_q && s_lf_ok && !wake_q; // [R2] [R18]
	// Wake done only once the PLL enable has settled, so a stale flag cannot pass
	assign wake_done = (state_q == pmc_pkg::ST_WAKE_PLL) && (o_pll_en != s_pll_pd)
		&& pll_stable && s_mo_ok; // [R20] [R23]

	// Wake-up latch held until acknowledge
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
			wake_q <= 1'b0;
		else if (s_wake)
			wake_q <= 1'b1; // [R22]
		else if (s_ack)
			wake_q <= 1'b0;
	end

	// Mode state machine
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			state_q    <= pmc_pkg::ST_ACTIVE; // [R26]
			gate_cnt_q <= 2'd0;
		end
		else
		begin
			case (state_q)
				pmc_pkg::ST_ACTIVE:
				begin
					if (go_wait && halt_q)
					begin
						state_q    <= pmc_pkg::ST_HALT_STOP; // [R8]
						gate_cnt_q <= 2'(pmc_pkg::GATE_CYCLES);
					end
					else if (go_wait && idle_q)
						state_q <= pmc_pkg::ST_IDLE; // [R6]
					else if (go_wait && psave_q)
						state_q <= pmc_pkg::ST_PSAVE; // [R2]
					else if (go_ps_now)
						state_q <= pmc_pkg::ST_PSAVE; // [R1]
				end
				pmc_pkg::ST_HALT_STOP:
				begin
					// System clock already stopped; count before oscillators go
					if (gate_cnt_q == 2'd0)
						state_q <= pmc_pkg::ST_HALT; // [R9]
					else
						gate_cnt_q <= gate_cnt_q - 2'd1;
				end
				pmc_pkg::ST_PSAVE:
				begin
					if (wake_q)
						state_q <= pmc_pkg::ST_WAKE_OSC; // [R23]
					else if (wr_ctl && !i_reg_wdata[pmc_pkg::BIT_PSAVE])
						state_q <= pmc_pkg::ST_WAKE_OSC; // [R25]
				end
				pmc_pkg::ST_IDLE, pmc_pkg::ST_HALT:
				begin
					if (wake_q)
						state_q <= pmc_pkg::ST_WAKE_OSC; // [R10]
				end
				pmc_pkg::ST_WAKE_OSC:
				begin
					if (s_mo_ok)
						state_q <= pmc_pkg::ST_WAKE_PLL; // [R19] [R23]
				end
				pmc_pkg::ST_WAKE_PLL:
				begin
					if (wake_done)
						state_q <= pmc_pkg::ST_ACTIVE; // [R20] [R23]
				end
				default:
					state_q <= pmc_pkg::ST_ACTIVE;
			endcase
		end
	end

	// Control bits: mode requests and indications
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			psave_q   <= pmc_pkg::CONTROL_RESET[pmc_pkg::BIT_PSAVE];
			idle_q    <= pmc_pkg::CONTROL_RESET[pmc_pkg::BIT_IDLE];
			halt_q    <= pmc_pkg::CONTROL_RESET[pmc_pkg::BIT_HALT];
			ps_pend_q <= 1'b0;
		end
		else if (wake_done)
		begin
			// Indications drop once Active is reached
			psave_q   <= 1'b0; // [R5] [R7] [R10] [R25]
			idle_q    <= 1'b0;
			halt_q    <= 1'b0;
			ps_pend_q <= 1'b0;
		end
		else if (state_q == pmc_pkg::ST_ACTIVE && go_ps_now)
		begin
			psave_q   <= 1'b1; // [R3]
			ps_pend_q <= 1'b0;
		end
		else if (wr_ctl && !low_power)
		begin
			// One request at a time; halt over idle over power save
			halt_q <= i_reg_wdata[pmc_pkg::BIT_HALT];
			idle_q <= i_reg_wdata[pmc_pkg::BIT_IDLE] && !i_reg_wdata[pmc_pkg::BIT_HALT]; // [R26]
			if (!i_reg_wdata[pmc_pkg::BIT_PSAVE] || i_reg_wdata[pmc_pkg::BIT_HALT]
				|| i_reg_wdata[pmc_pkg::BIT_IDLE])
			begin
				psave_q   <= 1'b0; // [R5] [R26]
				ps_pend_q <= 1'b0;
			end
			else if (!psave_q)
			begin
				if (i_reg_wdata[pmc_pkg::BIT_WBLP])
					psave_q <= 1'b1; // [R4]
				else
					ps_pend_q <= 1'b1; // [R1] [R3]
			end
		end
	end

	// Wait bit and clock disable bits
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			wblp_q <= pmc_pkg::CONTROL_RESET[pmc_pkg::BIT_WBLP];
			mdis_q <= pmc_pkg::CONTROL_RESET[pmc_pkg::BIT_MDIS];
			pdis_q <= pmc_pkg::CONTROL_RESET[pmc_pkg::BIT_PDIS];
		end
		else if (state_q == pmc_pkg::ST_WAKE_OSC || (low_power && wake_q))
		begin
			mdis_q <= 1'b0; // [R14] [R23]
			if (state_q == pmc_pkg::ST_WAKE_OSC && s_mo_ok)
				pdis_q <= 1'b0; // [R16] [R23]
		end
		else if (wr_ctl)
		begin
			wblp_q <= i_reg_wdata[pmc_pkg::BIT_WBLP]; // [R11]
			mdis_q <= i_reg_wdata[pmc_pkg::BIT_MDIS];
			pdis_q <= i_reg_wdata[pmc_pkg::BIT_PDIS]; // [R17]
		end
	end

	// Clock gating outputs, all registered
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			o_sys_clk_en     <= 1'b1;
			o_sys_clk_slow   <= 1'b0;
			o_main_osc_en    <= 1'b1;
			o_pll_en         <= 1'b1;
			o_wakeup_pending <= 1'b0;
		end
		else
		begin
			o_wakeup_pending <= wake_q;
			o_sys_clk_en     <= (state_q == pmc_pkg::ST_ACTIVE)
				|| (state_q == pmc_pkg::ST_PSAVE) || (state_q == pmc_pkg::ST_WAKE_OSC)
				|| (state_q == pmc_pkg::ST_WAKE_PLL); // [R9]
			o_sys_clk_slow   <= low_power;
			case (state_q)
				pmc_pkg::ST_ACTIVE:
				begin
					o_main_osc_en <= 1'b1; // [R13]
					o_pll_en      <= !s_pll_pd;
				end
				pmc_pkg::ST_PSAVE:
				begin
					o_main_osc_en <= !mdis_q; // [R12] [R13]
					o_pll_en      <= !pdis_q && !s_pll_pd; // [R15]
				end
				pmc_pkg::ST_HALT_STOP:
				begin
					o_main_osc_en <= 1'b1; // [R9]
					o_pll_en      <= !s_pll_pd;
				end
				pmc_pkg::ST_WAKE_OSC:
				begin
					o_main_osc_en <= 1'b1; // [R10]
					o_pll_en      <= !pdis_q && !s_pll_pd; // [R23]
				end
				pmc_pkg::ST_WAKE_PLL:
				begin
					o_main_osc_en <= 1'b1;
					o_pll_en      <= !s_pll_pd;
				end
				default:
				begin
					o_main_osc_en <= 1'b0; // [R12]
					o_pll_en      <= 1'b0;
				end
			endcase
		end
	end

	// Read data, valid in the cycle after the read strobe
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
			o_reg_rdata <= 8'h00;
		else if (i_reg_rd)
		begin
			if (i_reg_addr == pmc_pkg::ADDR_CONTROL)
				o_reg_rdata <= {2'b00, pdis_q, mdis_q, wblp_q, halt_q, idle_q, psave_q};
			else if (i_reg_addr == pmc_pkg::ADDR_STATUS)
				o_reg_rdata <= {5'b00000, pll_stable, s_mo_ok, s_lf_ok}; // [R21]
			else
				o_reg_rdata <= 8'h00;
		end
		else
			o_reg_rdata <= 8'h00;
	end

	// Low-power entry refused without stable low-frequency clock
	a_lf_entry_guard: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R18]
		($rose(low_power) && state_q != pmc_pkg::ST_WAKE_OSC) |-> $past(s_lf_ok))
		else $error("low-power entry without stable slow clock");

	// Active only reached with main oscillator stable
	a_active_osc_ok: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R19]
		($past(state_q) == pmc_pkg::ST_WAKE_PLL && state_q == pmc_pkg::ST_ACTIVE)
		|-> $past(s_mo_ok) && $past(pll_stable))
		else $error("active entered with unstable clock");

	// Halt stops system clock before oscillators
	a_halt_clk_order: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R9]
		$fell(o_main_osc_en) && state_q == pmc_pkg::ST_HALT |-> !$past(o_sys_clk_en))
		else $error("oscillator stopped before system clock");

	// Immediate request sets bit only with entry
	a_psave_immediate: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R3]
		(wr_ctl && i_reg_wdata[pmc_pkg::BIT_PSAVE] && !i_reg_wdata[pmc_pkg::BIT_WBLP]
		&& state_q == pmc_pkg::ST_ACTIVE && !psave_q && !ps_pend_q) |=> !psave_q)
		else $error("power-save bit set before entry");

	// Deferred request sets bit at once
	a_psave_deferred: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R4]
		(wr_ctl && i_reg_wdata[pmc_pkg::BIT_PSAVE] && i_reg_wdata[pmc_pkg::BIT_WBLP]
		&& !i_reg_wdata[pmc_pkg::BIT_HALT] && !i_reg_wdata[pmc_pkg::BIT_IDLE]
		&& state_q == pmc_pkg::ST_ACTIVE) |=> psave_q)
		else $error("deferred power-save bit not set on write");

	// At most one mode indication
	a_one_mode_bit: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R26]
		$onehot0({psave_q, idle_q, halt_q}))
		else $error("more than one mode bit set");

	// Wake-up in low power clears main disable
	a_wake_clears_mdis: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R14]
		(state_q == pmc_pkg::ST_WAKE_OSC) |=> !mdis_q)
		else $error("main-clock-disable not cleared on wake");

	// Wake latch held until acknowledge
	a_wake_latched: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R22]
		(wake_q && !s_ack) |=> wake_q)
		else $error("wake-up latch dropped early");

	// Active ignores the oscillator disable bit
	a_active_osc_on: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R13]
		(state_q == pmc_pkg::ST_ACTIVE) |=> o_main_osc_en)
		else $error("oscillator off in active mode");

	// Active only after the PLL enable has settled
	a_pll_settled: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R20]
		($past(state_q) == pmc_pkg::ST_WAKE_PLL && state_q == pmc_pkg::ST_ACTIVE)
		|-> $past(o_pll_en) != $past(s_pll_pd))
		else $error("active entered before PLL enable settled");

endmodule

/* pmc_pkg.sv */
// Package for the power mode controller: register map, field positions,
// reset values and the mode state type. Assumes a single 50 MHz clock.
package pmc_pkg;

	// Register offsets on the plain register port
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_STATUS  = 4'h2;

	// Control register field positions
	localparam int BIT_PSAVE = 0;
	localparam int BIT_IDLE  = 1;
	localparam int BIT_HALT  = 2;
	localparam int BIT_WBLP  = 3;
	localparam int BIT_MDIS  = 4;
	localparam int BIT_PDIS  = 5;

	// Reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// Clock gating handshake: cycles between stopping system clock and oscillators
	localparam int GATE_TIME_NS   = 40;
	localparam int CLK_PERIOD_NS  = 20;
	localparam int GATE_CYCLES    = (GATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Power modes
	typedef enum logic [2:0]
	{
		ST_ACTIVE,
		ST_PSAVE,
		ST_IDLE,
		ST_HALT_STOP,
		ST_HALT,
		ST_WAKE_OSC,
		ST_WAKE_PLL
	} pmc_state_type;

endpackage

/* pmc_clock_partner.sv */
// Clock source model: oscillator reports stable a set time after enable, PLL a set time after both enable and a stable oscillator.
// Assumes enables come from the controller on the system clock.
`timescale 1ns/1ns
module pmc_clock_partner
#(
	parameter int OSC_DELAY = 20,
	parameter int PLL_DELAY = 12
)
(
	// Clock
	input  wire logic i_clk_sys,
	// Enables from the controller
	input  wire logic i_main_osc_en,
	input  wire logic i_pll_en,
	// Stability reports
	output logic      o_main_osc_stable,
	output logic      o_pll_locked
);
	int osc_cnt = 0;
	int pll_cnt = 0;

	// Count while enabled; PLL needs a running reference, drops at once when off
	always @(posedge i_clk_sys)
	begin
		osc_cnt <= i_main_osc_en ? osc_cnt + 1 : 0;
		pll_cnt <= (i_pll_en && o_main_osc_stable) ? pll_cnt + 1 : 0;
	end

	// Reports low while starting or disabled
	assign o_main_osc_stable = (osc_cnt >= OSC_DELAY);
	assign o_pll_locked      = (pll_cnt >= PLL_DELAY);
endmodule

/* pmc_power_mode_controller_tb.sv */
// Self-checking bench for the power mode controller with a clock source model.
// Assumes a 50 MHz clock and register offsets from the package.
`timescale 1ns/1ns
module pmc_power_mode_controller_tb;
	logic       clk = 0;
	logic       rst = 1;
	logic [3:0] addr = '0;
	logic [7:0] wdata = '0;
	logic       wr = 0;
	logic       rd = 0;
	logic       cpu_wait = 0;
	logic       int_ack = 0;
	logic       nmi = 0;
	logic       wk = 0;
	logic       lf = 1;
	logic       ppd = 0;
	logic [7:0] rdata;
	logic       mo, pl, clk_en, slow, osc_en, pll_en, pend;
	int         bad_count = 0;
	int         samples_checked = 0;
	int         seed = 32'hebc2;
	int         exp_ctrl;
	logic [7:0] d;
	logic [3:0] a;
	int         k;

	// Clock generator
	always #10 clk = ~clk;

	pmc_power_mode_controller pmc_power_mode_controller_i
	(
		.i_clk_sys(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_cpu_wait(cpu_wait),
		.i_int_ack(int_ack), .i_nmi(nmi), .i_wakeup_input_unit(wk),
		.i_low_freq_stable(lf), .i_main_osc_stable(mo), .i_pll_locked(pl),
		.i_pll_power_down(ppd), .o_sys_clk_en(clk_en), .o_sys_clk_slow(slow),
		.o_main_osc_en(osc_en), .o_pll_en(pll_en), .o_wakeup_pending(pend)
	);

	pmc_clock_partner pmc_clock_partner_i
	(
		.i_clk_sys(clk), .i_main_osc_en(osc_en), .i_pll_en(pll_en),
		.o_main_osc_stable(mo), .o_pll_locked(pl)
	);

	// Compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One-cycle register write
	task automatic wr_reg(input logic [3:0] ad, input logic [7:0] dt);
		@(posedge clk);
		addr  <= ad;
		wdata <= dt;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read strobe, data taken in the following cycle
	task automatic rd_reg(input logic [3:0] ad, output logic [7:0] dt);
		@(posedge clk);
		addr <= ad;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		dt = rdata;
	endtask

	// Read until the expected value shows, bounded
	task automatic poll(input logic [3:0] ad, input logic [7:0] e);
		for (int n = 0; n < 80; n++)
		begin
			rd_reg(ad, d);
			if (d === e)
				break;
		end
		check(d, e);
	endtask

	task automatic ack_wake();
		int_ack <= 1'b1;
		repeat (3) @(posedge clk);
		int_ack <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		check(8'(pend), 8'h00);
	endtask

	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		#400000;
		bad_count++;
		end_sim();
	end

	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (40) @(posedge clk);
		exp_ctrl = pmc_pkg::CONTROL_RESET;
		rd_reg(pmc_pkg::ADDR_CONTROL, d);
		check(d, exp_ctrl[7:0]);
		poll(pmc_pkg::ADDR_STATUS, 8'h07);
		// Unmapped places read zero and ignore writes
		repeat (4)
		begin
			a = 4'($random(seed));
			if (a == pmc_pkg::ADDR_CONTROL || a == pmc_pkg::ADDR_STATUS)
				a = 4'h1;
			wr_reg(a, 8'($random(seed)));
			rd_reg(a, d);
			check(d, 8'h00);
		end
		// Active keeps the oscillator on
		wr_reg(pmc_pkg::ADDR_CONTROL, 8'h10);
		repeat (6) @(posedge clk);
		check(8'(osc_en), 8'h01);
		// Slow clock unstable: entry refused
		lf <= 1'b0;
		repeat (4) @(posedge clk);
		wr_reg(pmc_pkg::ADDR_CONTROL, 8'h11);
		repeat (10) @(posedge clk);
		rd_reg(pmc_pkg::ADDR_CONTROL, d);
		check(d, 8'h10);
		check(8'(slow), 8'h00);
		lf <= 1'b1;
		poll(pmc_pkg::ADDR_CONTROL, 8'h11);
		check(8'(slow), 8'h01);
		check(8'(osc_en), 8'h00);
		check(8'(pll_en), 8'h01);
		poll(pmc_pkg::ADDR_STATUS, 8'h01);
		// Software exit: bit stays set until Active is reached
		wr_reg(pmc_pkg::ADDR_CONTROL, 8'h00);
		rd_reg(pmc_pkg::ADDR_CONTROL, d);
		check(d, 8'h01);
		check(8'(slow), 8'h01);
		poll(pmc_pkg::ADDR_CONTROL, 8'h00);
		check(8'(slow), 8'h00);
		// Deferred idle, both disables set first
		wr_reg(pmc_pkg::ADDR_CONTROL, 8'h3A);
		rd_reg(pmc_pkg::ADDR_CONTROL, d);
		check(d, 8'h3A);
		repeat (10) @(posedge clk);
		check(8'({slow, osc_en}), 8'h01);
		cpu_wait <= 1'b1;
		for (k = 0; k < 40 && clk_en !== 1'b0; k++)
			@(posedge clk) #1;
		cpu_wait <= 1'b0;
		repeat (8) @(posedge clk);
		check(8'({slow, osc_en, pll_en}), 8'h04);
		wk <= 1'b1;
		repeat (3) @(posedge clk);
		wk <= 1'b0;
		poll(pmc_pkg::ADDR_CONTROL, 8'h08);
		check(8'({clk_en, slow, pend}), 8'h05);
		ack_wake();
		// Halt: system clock stops before oscillators
		wr_reg(pmc_pkg::ADDR_CONTROL, 8'h3C);
		cpu_wait <= 1'b1;
		for (k = 0; k < 40 && clk_en !== 1'b0; k++)
			@(posedge clk) #1;
		check(8'(osc_en), 8'h01);
		cpu_wait <= 1'b0;
		repeat (8) @(posedge clk);
		check(8'({clk_en, osc_en, pll_en}), 8'h00);
		rd_reg(pmc_pkg::ADDR_CONTROL, d);
		check(d, 8'h3C);
		nmi <= 1'b1;
		for (k = 0; k < 40 && osc_en !== 1'b1; k++)
			@(posedge clk) #1;
		nmi <= 1'b0;
		check(8'(pll_en), 8'h00);
		rd_reg(pmc_pkg::ADDR_CONTROL, d);
		check(d, 8'h2C);
		poll(pmc_pkg::ADDR_CONTROL, 8'h08);
		check(8'({clk_en, osc_en, pll_en}), 8'h07);
		ack_wake();
		// Deferred power save: bit set on write, entry waits for WAIT
		wr_reg(pmc_pkg::ADDR_CONTROL, 8'h09);
		rd_reg(pmc_pkg::ADDR_CONTROL, d);
		check(d, 8'h09);
		repeat (6) @(posedge clk);
		#1;
		check(8'(slow), 8'h00);
		cpu_wait <= 1'b1;
		repeat (4) @(posedge clk);
		cpu_wait <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		check(8'({slow, osc_en, pll_en}), 8'h07);
		wk <= 1'b1;
		repeat (3) @(posedge clk);
		wk <= 1'b0;
		poll(pmc_pkg::ADDR_CONTROL, 8'h08);
		check(8'({clk_en, slow}), 8'h02);
		ack_wake();
		end_sim();
	end
endmodule
